// >>> design/light_proximity_readout_irq.sv
// Light and proximity readout with serial slave port and interrupt logic
`timescale 1ns/10ps
`include "sensor_consts.svh"

module light_proximity_readout_irq #(
  parameter int LIGHT_PERIOD_CYC = `LIGHT_PERIOD_US * `CORE_CLK_MHZ,
  parameter int NEAR_MEAS_CYC    = `NEAR_MEAS_US * `CORE_CLK_MHZ,
  parameter int SLEEP_UNIT_CYC   = `SLEEP_UNIT_US * `CORE_CLK_MHZ
) (
  input  wire logic                        core_clk,
  input  wire logic                        rstn,
  input  wire logic                        link_clk,
  input  wire logic                        scl_i,
  input  wire logic                        sda_i,
  output logic                             sda_o,
  output logic                             sda_oe,
  input  wire logic                        address_select_pin,
  input  wire sensor_pkg::analog_sample_t  samples,
  output logic                             led_sink_pin,
  output logic                             led_drive_strength,
  output logic                             light_measure_type,
  output logic                             light_gain_select,
  output logic                             int_n
);
  import sensor_pkg::*;

  localparam int LED_ON_CYC = `LED_ON_US * `CORE_CLK_MHZ;

  // ==========================================================
  // Converter sequencing, core clock domain
  typedef struct packed {
    logic [7:0]  cfg_s1;
    sensor_cfg_t cfg;
    logic [19:0] light_cnt;
    logic [11:0] light_result;
    logic        light_tgl;
    near_state_t near_st;
    logic [23:0] near_cnt;
    logic [7:0]  near_lit;
    logic [7:0]  near_result;
    logic        near_tgl;
    logic        led;
  } core_state_t;

  // ==========================================================
  // Serial port, registers and interrupt, link clock domain
  typedef struct packed {
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic [1:0]  adr_s;
    logic [2:0]  light_tgl_s;
    logic [2:0]  near_tgl_s;
    bus_state_t  st;
    logic [3:0]  bit_cnt;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic        want_ptr;
    logic        rd_dir;
    logic        master_ack;
    logic        oe;
    logic [7:0]  cfg;
    logic [7:0]  int_ctrl;
    logic [7:0]  near_low;
    logic [7:0]  near_high;
    logic [7:0]  th_a;
    logic [7:0]  th_b;
    logic [7:0]  th_c;
    logic [7:0]  near_count;
    logic [11:0] light_data;
    logic [4:0]  near_run;
    logic [4:0]  light_run;
    logic        irq_n;
  } link_state_t;

  core_state_t c_reg, c_next;
  link_state_t l_reg, l_next;

  function automatic logic [4:0] run_needed(input logic [1:0] code);
    unique case (code)
      2'b00: run_needed = 5'h01;
      2'b01: run_needed = 5'h04;
      2'b10: run_needed = 5'h08;
      2'b11: run_needed = 5'h10;
    endcase
  endfunction

  function automatic logic [7:0] read_mux(input link_state_t s);
    unique case (s.ptr)
      `OFS_CONFIG:     read_mux = s.cfg;
      `OFS_INT_CTRL:   read_mux = s.int_ctrl;
      `OFS_NEAR_LOW:   read_mux = s.near_low;
      `OFS_NEAR_HIGH:  read_mux = s.near_high;
      `OFS_LIGHT_TH_A: read_mux = s.th_a;
      `OFS_LIGHT_TH_B: read_mux = s.th_b;
      `OFS_LIGHT_TH_C: read_mux = s.th_c;
      `OFS_NEAR_COUNT: read_mux = s.near_count;
      `OFS_LIGHT_LOW:  read_mux = s.light_data[7:0];
      `OFS_LIGHT_HIGH: read_mux = {4'h0, s.light_data[11:8]};
      default:         read_mux = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // Core domain next state
  logic [23:0] sleep_cyc;
  logic [7:0]  near_diff;

  always_comb begin
    c_next = c_reg;
    // Config is quasi-static, so per-bit two-flop sync is enough
    c_next.cfg_s1 = l_reg.cfg;
    c_next.cfg    = sensor_cfg_t'(c_reg.cfg_s1);
    sleep_cyc = 24'(SLEEP_UNIT_CYC) *
                {21'h0, 3'h7 - c_reg.cfg.near_sleep_period};
    near_diff = (c_reg.near_lit > samples.near_dark) ?
                8'(c_reg.near_lit - samples.near_dark) : 8'h00;

    // Light channel, free running while enabled
    if (!c_reg.cfg.light_channel_enable) begin
      c_next.light_cnt = 20'h0;
    end else if (c_reg.light_cnt == 20'(LIGHT_PERIOD_CYC - 1)) begin
      c_next.light_cnt    = 20'h0;
      c_next.light_result = samples.light;
      c_next.light_tgl    = ~c_reg.light_tgl;
    end else begin
      c_next.light_cnt = c_reg.light_cnt + 20'h1;
    end

    // Near channel, independent of the light channel
    c_next.near_cnt = c_reg.near_cnt + 24'h1;
    unique case (c_reg.near_st)
      NEAR_OFF: begin
        c_next.near_cnt = 24'h0;
        if (c_reg.cfg.near_enable) begin
          c_next.near_st = NEAR_LED;
          c_next.led     = 1'b1;
        end
      end
      NEAR_LED: begin
        if (c_reg.near_cnt == 24'(LED_ON_CYC - 1)) begin
          c_next.near_lit = samples.near_lit;
          c_next.led      = 1'b0;
          c_next.near_st  = NEAR_REST;
        end
      end
      NEAR_REST: begin
        if (c_reg.near_cnt == 24'(NEAR_MEAS_CYC - 1)) begin
          c_next.near_result = near_diff;
          c_next.near_tgl    = ~c_reg.near_tgl;
          c_next.near_cnt    = 24'h0;
          if (sleep_cyc == 24'h0) begin
            c_next.near_st = NEAR_LED;
            c_next.led     = 1'b1;
          end else begin
            c_next.near_st = NEAR_SLEEP;
          end
        end
      end
      NEAR_SLEEP: begin
        if (c_reg.near_cnt >= sleep_cyc - 24'h1) begin
          c_next.near_cnt = 24'h0;
          c_next.near_st  = NEAR_LED;
          c_next.led      = 1'b1;
        end
      end
    endcase
    if (!c_reg.cfg.near_enable) begin
      c_next.near_st  = NEAR_OFF;
      c_next.near_cnt = 24'h0;
      c_next.led      = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  // ==========================================================
  // Link domain next state
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic        light_new;
  logic        near_new;
  logic        light_out;
  logic        near_out;
  logic        light_set;
  logic        near_set;
  logic        flag_l;
  logic        flag_n;
  logic [11:0] light_lo;
  logic [11:0] light_hi;
  logic [7:0]  rd_byte;
  logic [4:0]  run;

  always_comb begin
    l_next = l_reg;
    l_next.scl_s       = {l_reg.scl_s[1:0], scl_i};
    l_next.sda_s       = {l_reg.sda_s[1:0], sda_i};
    l_next.adr_s       = {l_reg.adr_s[0], address_select_pin};
    l_next.light_tgl_s = {l_reg.light_tgl_s[1:0], c_reg.light_tgl};
    l_next.near_tgl_s  = {l_reg.near_tgl_s[1:0], c_reg.near_tgl};
    scl_rise  = l_reg.scl_s[1] & ~l_reg.scl_s[2];
    scl_fall  = ~l_reg.scl_s[1] & l_reg.scl_s[2];
    bus_start = l_reg.scl_s[1] & l_reg.scl_s[2] &
                ~l_reg.sda_s[1] & l_reg.sda_s[2];
    bus_stop  = l_reg.scl_s[1] & l_reg.scl_s[2] &
                l_reg.sda_s[1] & ~l_reg.sda_s[2];
    light_new = l_reg.light_tgl_s[1] ^ l_reg.light_tgl_s[2];
    near_new  = l_reg.near_tgl_s[1] ^ l_reg.near_tgl_s[2];
    rd_byte   = read_mux(l_reg);
    light_set = 1'b0;
    near_set  = 1'b0;
    run       = 5'h0;

    // Result capture; core holds data for thousands of cycles
    if (light_new) begin
      l_next.light_data = c_reg.light_result;
    end
    if (near_new) begin
      l_next.near_count = c_reg.near_result;
    end

    // Window comparators, run once per fresh result
    light_lo  = {l_reg.th_b[3:0], l_reg.th_a};
    light_hi  = {l_reg.th_c, l_reg.th_b[7:4]};
    light_out = (c_reg.light_result < light_lo) ||
                (c_reg.light_result > light_hi);
    near_out  = (c_reg.near_result < l_reg.near_low) ||
                (c_reg.near_result > l_reg.near_high);
    if (light_new) begin
      if (light_out) begin
        run = (l_reg.light_run == 5'h10) ? 5'h10 :
              l_reg.light_run + 5'h1;
        l_next.light_run = run;
        light_set = run >= run_needed(l_reg.int_ctrl[
          `INT_LIGHT_PERS_HI:`INT_LIGHT_PERS_LO]);
      end else begin
        l_next.light_run = 5'h0;
      end
    end
    if (near_new) begin
      if (near_out) begin
        run = (l_reg.near_run == 5'h10) ? 5'h10 :
              l_reg.near_run + 5'h1;
        l_next.near_run = run;
        near_set = run >= run_needed(l_reg.int_ctrl[
          `INT_NEAR_PERS_HI:`INT_NEAR_PERS_LO]);
      end else begin
        l_next.near_run = 5'h0;
      end
    end

    // Serial slave
    unique case (l_reg.st)
      BUS_IDLE: begin
        l_next.oe = 1'b0;
      end
      BUS_ADDR: begin
        if (scl_rise) begin
          l_next.shreg   = {l_reg.shreg[6:0], l_reg.sda_s[1]};
          l_next.bit_cnt = l_reg.bit_cnt + 4'h1;
        end else if (scl_fall && l_reg.bit_cnt == 4'h8) begin
          if (l_reg.shreg[7:1] == {`SLAVE_ADDR_UPPER,
                                   l_reg.adr_s[1]}) begin
            l_next.oe     = 1'b1;
            l_next.rd_dir = l_reg.shreg[0];
            l_next.st     = BUS_ADDR_ACK;
          end else begin
            l_next.st = BUS_IDLE;
          end
        end
      end
      BUS_ADDR_ACK: begin
        if (scl_fall) begin
          l_next.bit_cnt = 4'h0;
          if (l_reg.rd_dir) begin
            l_next.shreg = rd_byte;
            l_next.oe    = ~rd_byte[7];
            l_next.ptr   = l_reg.ptr + 8'h1;
            l_next.st    = BUS_READ;
          end else begin
            l_next.oe = 1'b0;
            l_next.st = BUS_WRITE;
          end
        end
      end
      BUS_WRITE: begin
        if (scl_rise) begin
          l_next.shreg   = {l_reg.shreg[6:0], l_reg.sda_s[1]};
          l_next.bit_cnt = l_reg.bit_cnt + 4'h1;
        end else if (scl_fall && l_reg.bit_cnt == 4'h8) begin
          l_next.oe       = 1'b1;
          l_next.st       = BUS_WRITE_ACK;
          l_next.want_ptr = 1'b0;
          if (l_reg.want_ptr) begin
            l_next.ptr = l_reg.shreg;
          end else begin
            l_next.ptr = l_reg.ptr + 8'h1;
            unique case (l_reg.ptr)
              `OFS_CONFIG:     l_next.cfg       = l_reg.shreg;
              `OFS_INT_CTRL: begin
                // Flag bits only ever clear from a write
                l_next.int_ctrl = l_reg.shreg;
                l_next.int_ctrl[`INT_NEAR_FLAG_BIT] =
                  l_reg.int_ctrl[`INT_NEAR_FLAG_BIT] &
                  l_reg.shreg[`INT_NEAR_FLAG_BIT];
                l_next.int_ctrl[`INT_LIGHT_FLAG_BIT] =
                  l_reg.int_ctrl[`INT_LIGHT_FLAG_BIT] &
                  l_reg.shreg[`INT_LIGHT_FLAG_BIT];
              end
              `OFS_NEAR_LOW:   l_next.near_low  = l_reg.shreg;
              `OFS_NEAR_HIGH:  l_next.near_high = l_reg.shreg;
              `OFS_LIGHT_TH_A: l_next.th_a      = l_reg.shreg;
              `OFS_LIGHT_TH_B: l_next.th_b      = l_reg.shreg;
              `OFS_LIGHT_TH_C: l_next.th_c      = l_reg.shreg;
              default: ;
            endcase
          end
        end
      end
      BUS_WRITE_ACK: begin
        if (scl_fall) begin
          l_next.oe      = 1'b0;
          l_next.bit_cnt = 4'h0;
          l_next.st      = BUS_WRITE;
        end
      end
      BUS_READ: begin
        if (scl_rise) begin
          l_next.bit_cnt = l_reg.bit_cnt + 4'h1;
        end else if (scl_fall) begin
          if (l_reg.bit_cnt == 4'h8) begin
            l_next.oe = 1'b0;
            l_next.st = BUS_READ_ACK;
          end else begin
            l_next.shreg = {l_reg.shreg[6:0], 1'b0};
            l_next.oe    = ~l_reg.shreg[6];
          end
        end
      end
      BUS_READ_ACK: begin
        if (scl_rise) begin
          l_next.master_ack = ~l_reg.sda_s[1];
        end else if (scl_fall) begin
          l_next.bit_cnt = 4'h0;
          if (l_reg.master_ack) begin
            l_next.shreg = rd_byte;
            l_next.oe    = ~rd_byte[7];
            l_next.ptr   = l_reg.ptr + 8'h1;
            l_next.st    = BUS_READ;
          end else begin
            l_next.st = BUS_IDLE;
          end
        end
      end
      default: begin
        l_next.st = BUS_IDLE;
        l_next.oe = 1'b0;
      end
    endcase
    // Start and stop override any bit state; pointer survives restart
    if (bus_start) begin
      l_next.st       = BUS_ADDR;
      l_next.bit_cnt  = 4'h0;
      l_next.want_ptr = 1'b1;
      l_next.oe       = 1'b0;
    end else if (bus_stop) begin
      l_next.st = BUS_IDLE;
      l_next.oe = 1'b0;
    end

    // Hardware set wins over a clearing write in the same cycle
    if (light_set) begin
      l_next.int_ctrl[`INT_LIGHT_FLAG_BIT] = 1'b1;
    end
    if (near_set) begin
      l_next.int_ctrl[`INT_NEAR_FLAG_BIT] = 1'b1;
    end
    flag_l = l_reg.int_ctrl[`INT_LIGHT_FLAG_BIT];
    flag_n = l_reg.int_ctrl[`INT_NEAR_FLAG_BIT];
    l_next.irq_n = l_reg.int_ctrl[`INT_AND_SEL_BIT] ?
                   ~(flag_l & flag_n) : ~(flag_l | flag_n);
  end

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      l_reg           <= '0;
      l_reg.scl_s     <= 3'h7;
      l_reg.sda_s     <= 3'h7;
      l_reg.cfg       <= `RST_CONFIG;
      l_reg.int_ctrl  <= `RST_INT_CTRL;
      l_reg.near_low  <= `RST_NEAR_LOW;
      l_reg.near_high <= `RST_NEAR_HIGH;
      l_reg.th_a      <= `RST_LIGHT_TH_A;
      l_reg.th_b      <= `RST_LIGHT_TH_B;
      l_reg.th_c      <= `RST_LIGHT_TH_C;
      l_reg.want_ptr  <= 1'b1;
      l_reg.irq_n     <= 1'b1;
    end else begin
      l_reg <= l_next;
    end
  end

  // ==========================================================
  // Outputs, all but the tied-low sda_o straight from flip-flops
  assign sda_o              = 1'b0;
  assign sda_oe             = l_reg.oe;
  assign int_n              = l_reg.irq_n;
  assign led_sink_pin       = c_reg.led;
  assign led_drive_strength = c_reg.cfg.led_drive_strength;
  assign light_measure_type = c_reg.cfg.light_measure_type;
  assign light_gain_select  = c_reg.cfg.light_gain_select;

endmodule // light_proximity_readout_irq

// >>> design/sensor_consts.svh
// Offsets, field positions, reset values and timing of the sensor block
`ifndef SENSOR_CONSTS_SVH
`define SENSOR_CONSTS_SVH

// ==========================================================
// Slave address and register offsets
`define SLAVE_ADDR_UPPER    6'h22
`define OFS_CONFIG          8'h01
`define OFS_INT_CTRL        8'h02
`define OFS_NEAR_LOW        8'h03
`define OFS_NEAR_HIGH       8'h04
`define OFS_LIGHT_TH_A      8'h05
`define OFS_LIGHT_TH_B      8'h06
`define OFS_LIGHT_TH_C      8'h07
`define OFS_NEAR_COUNT      8'h08
`define OFS_LIGHT_LOW       8'h09
`define OFS_LIGHT_HIGH      8'h0A

// ==========================================================
// Interrupt control field positions
`define INT_NEAR_FLAG_BIT   7
`define INT_NEAR_PERS_HI    6
`define INT_NEAR_PERS_LO    5
`define INT_LIGHT_FLAG_BIT  3
`define INT_LIGHT_PERS_HI   2
`define INT_LIGHT_PERS_LO   1
`define INT_AND_SEL_BIT     0

// ==========================================================
// Reset values
`define RST_CONFIG          8'h00
`define RST_INT_CTRL        8'h00
`define RST_NEAR_LOW        8'h00
`define RST_NEAR_HIGH       8'hFF
`define RST_LIGHT_TH_A      8'h00
`define RST_LIGHT_TH_B      8'hF0
`define RST_LIGHT_TH_C      8'hFF

// ==========================================================
// Timing, in microseconds, at the core clock rate
`define CORE_CLK_MHZ        10
`define LIGHT_PERIOD_US     100000
`define NEAR_MEAS_US        540
`define LED_ON_US           100
`define SLEEP_UNIT_US       100000

`endif

// >>> design/sensor_pkg.sv
// Types shared by the light and proximity readout block
package sensor_pkg;

  typedef struct packed {
    logic [11:0] light;
    logic [7:0]  near_lit;
    logic [7:0]  near_dark;
  } analog_sample_t;

  typedef struct packed {
    logic       near_enable;
    logic [2:0] near_sleep_period;
    logic       led_drive_strength;
    logic       light_channel_enable;
    logic       light_gain_select;
    logic       light_measure_type;
  } sensor_cfg_t;

  typedef enum logic [1:0] {
    NEAR_OFF   = 2'b00,
    NEAR_LED   = 2'b01,
    NEAR_REST  = 2'b10,
    NEAR_SLEEP = 2'b11
  } near_state_t;

  typedef enum logic [2:0] {
    BUS_IDLE      = 3'b000,
    BUS_ADDR      = 3'b001,
    BUS_ADDR_ACK  = 3'b010,
    BUS_WRITE     = 3'b011,
    BUS_WRITE_ACK = 3'b100,
    BUS_READ      = 3'b101,
    BUS_READ_ACK  = 3'b110
  } bus_state_t;

endpackage

// >>> tb/readout_properties.sv
// Serial port and LED timing checks of the readout block
`timescale 1ns/10ps
`include "sensor_consts.svh"

module readout_properties #(
  parameter int NEAR_MEAS_CYC = 5400
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic address_select_pin,
  input wire logic led_sink_pin
);
  localparam int LED_CYC = `LED_ON_US * `CORE_CLK_MHZ;
  // ==========
  // Helper state
  int unsigned on_cnt, off_cnt;
  logic        scl_q, sda_q, busy;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  wire         start_seen = scl_i & scl_q & sda_q & !sda_i;
  wire         stop_seen = scl_i & scl_q & !sda_q & sda_i;
  wire         ours = shift[7:1] == {6'h22, address_select_pin};

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      on_cnt <= 0;
      off_cnt <= 0;
    end else begin
      on_cnt <= led_sink_pin ? on_cnt + 1 : 0;
      off_cnt <= led_sink_pin ? 0 : off_cnt + 1;
    end
  end

  // Only the address byte is shifted; later bytes leave bit_cnt at 9
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      busy <= 1'b0;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      if (start_seen) begin
        busy <= 1'b1;
        bit_cnt <= 4'h0;
      end else if (stop_seen) begin
        busy <= 1'b0;
      end else if (scl_i && !scl_q && bit_cnt < 4'h9) begin
        bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt < 4'h8) begin
          shift <= {shift[6:0], sda_i};
        end
      end
    end
  end

  // ==========
  // Properties
  led_len_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    led_sink_pin |-> on_cnt < LED_CYC)
    else $error("LED drive held too long");
  led_gap_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $rose(led_sink_pin) |-> off_cnt >= NEAR_MEAS_CYC - LED_CYC - 1)
    else $error("LED drive periods too close");
  addr_ack_a: assert property (
    @(posedge link_clk) disable iff (!rstn)
    $fell(scl_i) && bit_cnt == 4'h8 && ours |-> ##[1:6] sda_oe)
    else $error("own address not acknowledged");
  foreign_addr_a: assert property (
    @(posedge link_clk) disable iff (!rstn)
    bit_cnt >= 4'h8 && !ours |-> !sda_oe)
    else $error("foreign address answered");
  idle_quiet_a: assert property (
    @(posedge link_clk) disable iff (!rstn) !busy |-> !sda_oe)
    else $error("data line driven outside a transfer");
  scl_low_a: assert property (
    @(posedge link_clk) disable iff (!rstn) $changed(sda_oe) |-> !scl_i)
    else $error("data line moved while clock high");
  open_drain_a: assert property (
    @(posedge link_clk) disable iff (!rstn) sda_oe |-> !sda_o)
    else $error("data line driven high");
  oe_release_a: assert property (
    @(posedge link_clk) disable iff (!rstn)
    $rose(sda_oe) |-> ##[1:400] !sda_oe)
    else $error("data line never released");
endmodule  // readout_properties

bind light_proximity_readout_irq readout_properties #(
  .NEAR_MEAS_CYC(NEAR_MEAS_CYC)
) i_readout_properties (
  .core_clk(core_clk), .rstn(rstn), .link_clk(link_clk), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .address_select_pin(address_select_pin), .led_sink_pin(led_sink_pin)
);

// >>> tb/bus_master_model.sv
// Two-wire bus master model facing the sensor's serial port
`timescale 1ns/10ps

module bus_master_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  // ==========
  // Bit level; clock halves of ten cycles keep well above the minimum
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    repeat (5) @(posedge clk);
    scl <= 1'b1;
    repeat (5) @(posedge clk);
    r = sda_line;
    repeat (5) @(posedge clk);
    scl <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  task automatic start_cond();
    sda_drv <= 1'b1;
    repeat (5) @(posedge clk);
    scl <= 1'b1;
    repeat (5) @(posedge clk);
    sda_drv <= 1'b0;
    repeat (5) @(posedge clk);
    scl <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  task automatic stop_cond();
    sda_drv <= 1'b0;
    repeat (5) @(posedge clk);
    scl <= 1'b1;
    repeat (5) @(posedge clk);
    sda_drv <= 1'b1;
    repeat (10) @(posedge clk);
  endtask
  task automatic send(input logic [7:0] v, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r);
    end
    bit_io(1'b1, r);
    ok = ok & !r;
  endtask
  // ==========
  // Register transfers, pointer byte first
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] d, output logic ok);
    ok = 1'b1;
    start_cond();
    send({dev, 1'b0}, ok);
    send(ptr, ok);
    send(d, ok);
    stop_cond();
  endtask
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr,
                          output logic [7:0] d, output logic ok);
    logic r;
    ok = 1'b1;
    start_cond();
    send({dev, 1'b0}, ok);
    send(ptr, ok);
    start_cond();
    send({dev, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
    stop_cond();
  endtask
endmodule  // bus_master_model

// >>> tb/tb_light_proximity_readout_irq.sv
// Self-checking bench of the light and proximity readout block
`timescale 1ns/10ps
`include "sensor_consts.svh"

module tb_light_proximity_readout_irq;
  import sensor_pkg::*;
  localparam int LP = 200;
  localparam int NM = 1100;
  localparam int LED = `LED_ON_US * `CORE_CLK_MHZ;
  logic           core_clk, link_clk, rstn, sel, scl, sda_m, sda_o, sda_oe;
  logic           led, drive, mtype, gain, int_n, ok;
  logic [7:0]     rd;
  analog_sample_t smp;
  int             bad_count, compares, cyc;
  wire            sda_line = sda_m & (sda_oe ? sda_o : 1'b1);
  wire [6:0]      dev = {6'h22, sel};

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end

  light_proximity_readout_irq #(
    .LIGHT_PERIOD_CYC(LP), .NEAR_MEAS_CYC(NM), .SLEEP_UNIT_CYC(100)
  ) i_light_proximity_readout_irq (
    .core_clk(core_clk), .rstn(rstn), .link_clk(link_clk), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .address_select_pin(sel), .samples(smp), .led_sink_pin(led),
    .led_drive_strength(drive), .light_measure_type(mtype),
    .light_gain_select(gain), .int_n(int_n)
  );
  bus_master_model i_bus_master_model (
    .clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_m)
  );

  // ==========
  // Shared tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_bus_master_model.write_reg(dev, a, d, ok);
    check({15'h0, ok}, 16'h0001);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_bus_master_model.read_reg(dev, a, rd, ok);
    check({7'h0, ok, rd}, {8'h01, e});
  endtask
  task automatic wait_pin(input logic on_int, input logic v, input int n);
    int k;
    k = 0;
    while ((on_int ? int_n : led) !== v && k < n) begin
      @(posedge core_clk);
      k++;
    end
    check({15'h0, (on_int ? int_n : led) === v}, 16'h0001);
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========
  // Scenarios
  task automatic t_reset();
    logic [7:0] e [11] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hF0,
                           8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    check({11'h0, led, drive, gain, mtype, int_n}, 16'h0001);
    for (int i = 0; i < 11; i++) begin
      rd_chk(8'(i + 1), e[i]);
    end
  endtask
  task automatic t_stranger();
    i_bus_master_model.write_reg({6'h22, ~sel}, 8'h03, 8'h55, ok);
    check({15'h0, ok}, 16'h0000);
    rd_chk(8'h03, 8'h00);
    wr(8'h08, 8'hAA);
    rd_chk(8'h08, 8'h00);
  endtask
  task automatic t_regs();
    logic [7:0] v [5] = '{8'h20, 8'h30, 8'h00, 8'h10, 8'h10};
    for (int i = 0; i < 5; i++) begin
      wr(8'(i + 3), v[i]);
    end
    for (int i = 0; i < 5; i++) begin
      rd_chk(8'(i + 3), v[i]);
    end
  endtask
  task automatic t_config();
    wr(8'h01, 8'h0B);
    repeat (5) @(posedge core_clk);
    check({12'h0, led, drive, gain, mtype}, 16'h0007);
    wr(8'h01, 8'h00);
    repeat (5) @(posedge core_clk);
    check({12'h0, led, drive, gain, mtype}, 16'h0000);
  endtask
  task automatic t_near();
    int n;
    wr(8'h02, 8'h20);
    wr(8'h01, 8'hF0);
    wait_pin(1'b0, 1'b1, 50);
    // First LED period began inside the write; time the next one whole
    wait_pin(1'b0, 1'b0, 1100);
    wait_pin(1'b0, 1'b1, 300);
    n = 0;
    while (led === 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    check(16'(n), 16'(LED));
    repeat (2) begin
      wait_pin(1'b0, 1'b1, 300);
      wait_pin(1'b0, 1'b0, 1100);
    end
    // Three results in, the fourth lands about 100 cycles later
    repeat (50) @(posedge core_clk);
    check({15'h0, int_n}, 16'h0001);
    wait_pin(1'b1, 1'b0, 1200);
    rd_chk(8'h08, 8'h40);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'hA0);
    check({15'h0, int_n}, 16'h0000);
    wr(8'h02, 8'h20);
    wait_pin(1'b1, 1'b1, 20);
  endtask
  task automatic t_light();
    smp.light <= 12'h101;
    wr(8'h02, 8'h00);
    wr(8'h01, 8'h04);
    repeat (3 * LP) @(posedge core_clk);
    check({15'h0, int_n}, 16'h0001);
    rd_chk(8'h09, 8'h01);
    rd_chk(8'h0A, 8'h01);
    smp.light <= 12'h7D0;
    wait_pin(1'b1, 1'b0, 2 * LP + 50);
    rd_chk(8'h09, 8'hD0);
    rd_chk(8'h0A, 8'h07);
    wr(8'h01, 8'h06);
    check({15'h0, gain}, 16'h0001);
    wr(8'h02, 8'h09);
    wait_pin(1'b1, 1'b1, 20);
    wr(8'h01, 8'h86);
    wait_pin(1'b1, 1'b0, 2500);
    rd_chk(8'h02, 8'h89);
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      $display("Error at %0t: timeout", $time);
      print_verdict();
    end
  end

  initial begin
    rstn = 1'b0;
    sel = 1'b1;
    smp = '{light: 12'h000, near_lit: 8'h50, near_dark: 8'h10};
    bad_count = 0;
    compares = 0;
    cyc = 0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (10) @(posedge core_clk);
    t_reset();
    t_stranger();
    t_regs();
    t_config();
    t_near();
    t_light();
    print_verdict();
  end
endmodule  // tb_light_proximity_readout_irq
